/* core/tlap_pkg.sv */
// shared constants and carrier types for the fan-driver motor-side logic
package tlap_pkg;

  // core clock rate, used to turn times into cycle counts
  localparam int CLK_KHZ = 250000;

  // protection times in milliseconds
  localparam int STALL_MS = 300;
  localparam int LOCK_SHORT_MS = 3500;
  localparam int LOCK_LONG_MS = 14000;
  localparam int RETRY_SHORT_MS = 700;
  localparam int RETRY_LONG_MS = 1000;

  // lockout repetitions: from this one on the long period applies
  localparam logic [2:0] LOCK_LONG_FROM = 3'h5;
  // hall changes needed before the stall indicator returns to normal
  localparam logic [2:0] HALL_CHG_CLEAR = 3'h4;
  // output duty below this code (of 255) counts as below 5 percent
  localparam logic [7:0] DUTY_LOW_LIM = 8'h0D;
  // 180 electrical degrees in steps of 0.05 degree
  localparam logic [11:0] HALF_TURN_05 = 12'hE10;
  // one 0.35 degree step in 0.05 degree units
  localparam logic [3:0] STEP_05 = 4'h7;
  // clamp of the interpolated lead angle, in 0.35 degree steps
  localparam int ANG_LIM = 128;

  // register byte offsets
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_DUTY_EP = 12'h004;
  localparam logic [11:0] OFS_STATUS = 12'h008;
  localparam logic [11:0] OFS_PERIOD = 12'h00C;

  // reset values of the writable fields
  localparam logic [1:0] TACH_SEL_RST = 2'h0;
  localparam logic [3:0] ADV_RST = 4'h0;
  localparam logic [7:0] TOP_DUTY_RST = 8'hFE;
  localparam logic [7:0] BOT_DUTY_RST = 8'h00;

  // speed pin selections
  localparam logic [1:0] TACH_BASIC = 2'h0;
  localparam logic [1:0] TACH_DOUBLE = 2'h1;
  localparam logic [1:0] TACH_HALF = 2'h2;
  localparam logic [1:0] TACH_STALL = 2'h3;

  // stall protection states
  typedef enum logic [1:0] {ST_RUN, ST_LOCKED, ST_RETRY, ST_REARM} tlap_state_e;

  // software configuration
  typedef struct packed {
    logic retry_window_long;
    logic advance_step_fine;
    logic [3:0] advance_at_bottom_duty;
    logic [3:0] advance_at_top_duty;
    logic stall_polarity_invert;
    logic [1:0] tach_output_select;
    logic [7:0] top_duty;
    logic [7:0] bottom_duty;
  } tlap_cfg_s;

endpackage

/* core/tlap_core.sv */
// motor-side logic: speed pin, lead angle, protection and stall lockout
// Summary of operation
// - basic speed pulse toggles at every hall crossing
// - tach select 0 basic, 1 double, 2 half, 3 stall indicator
// - with select 1 or 2 the speed pulse starts low after reset
// - two 4-bit lead settings, one at top duty, one at bottom
// - setting msb 0 delays commutation, 1 commutates ahead of hall
// - step bit 0 gives 0.70 degree steps, 1 gives 0.35 degree
// - endpoint angle is step size times setting value
// - angle interpolated linearly from output duty, also at full drive
// - thermal, overcurrent or stall lockout turn every bridge transistor off
// - low supply or current limit stop pwm, recirculate without sync rectifier
// - bridge resumes on its own once thermal shutdown releases
// - low supply drives one output low for input pairs 01 and 10, other hi-z; 00 and 11 leave both hi-z
// - no hall edge for over 0.3 s in rotation enters lockout
// - stall indicator low normal, high stalled; polarity bit inverts
// - indicator returns normal only after four hall changes
// - first four lockout periods 3.5 s, later ones 14 s
// - after lockout drive and wait 0.7 s or 1.0 s for an edge
// - low duty during a lockout period changes nothing, counting goes on
// - low duty in the retry window resets count, restarts on pwm rise
`timescale 1ns/1ps
`default_nettype none

module tlap_core #(
  parameter int PER_W = 24,
  parameter logic [31:0] STALL_CYC = 32'(64'(tlap_pkg::STALL_MS) * 64'(tlap_pkg::CLK_KHZ)),
  parameter logic [31:0] LOCK_SHORT_CYC =
    32'(64'(tlap_pkg::LOCK_SHORT_MS) * 64'(tlap_pkg::CLK_KHZ)),
  parameter logic [31:0] LOCK_LONG_CYC =
    32'(64'(tlap_pkg::LOCK_LONG_MS) * 64'(tlap_pkg::CLK_KHZ)),
  parameter logic [31:0] RETRY_SHORT_CYC =
    32'(64'(tlap_pkg::RETRY_SHORT_MS) * 64'(tlap_pkg::CLK_KHZ)),
  parameter logic [31:0] RETRY_LONG_CYC =
    32'(64'(tlap_pkg::RETRY_LONG_MS) * 64'(tlap_pkg::CLK_KHZ))
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // motor and duty inputs
  input wire logic hall_in,
  input wire logic pwm_in,
  input wire logic [7:0] output_duty,
  input wire logic pwm_carrier,
  // protection detectors and low-supply drive inputs
  input wire logic thermal_shutdown,
  input wire logic low_supply_lockout,
  input wire logic current_limiter,
  input wire logic overcurrent_trip,
  input wire logic drive_input_a,
  input wire logic drive_input_b,
  // bridge and speed pin
  output logic bridge_out_a_o,
  output logic bridge_out_a_oe,
  output logic bridge_out_b_o,
  output logic bridge_out_b_oe,
  output logic speed_pulse_out
);

  tlap_pkg::tlap_cfg_s cfg;
  tlap_pkg::tlap_state_e state;
  logic hall_q, pwm_q, hall_edge, pwm_rise, duty_low, hall_primed;
  logic [PER_W-1:0] per_cnt, period;
  logic [PER_W-1:0] lead_cyc, com_cnt, com_tgt;
  logic lead_adv, phase, com_armed, flip_to;
  logic [31:0] timer, lock_len, win_len;
  logic [2:0] lock_cnt, hall_chg;
  logic stall_flag, stall_trip, lock_done, retry_fail, go_locked, drive_ok;
  logic half_div, half_q, dbl_q, dbl_done;
  logic [PER_W-1:0] dbl_cnt;
  logic signed [6:0] ang_top, ang_bot;
  logic signed [9:0] duty_off, duty_span;
  logic signed [17:0] ang_num, ang_full;
  logic signed [9:0] ang_c;
  logic [10:0] ang_mag05;
  logic [PER_W+10:0] lead_prod;
  logic apb_acc, apb_wr, addr_ok;
  logic [31:0] next_rdata;
  localparam logic signed [17:0] ANG_LIM_S = 18'(tlap_pkg::ANG_LIM);

  // endpoint angle in 0.35 degree steps, signed: positive means ahead
  function automatic logic signed [6:0] to_steps(input logic [3:0] s, input logic fine);
    logic [6:0] m;
    m = fine ? {4'h0, s[2:0]} : {3'h0, s[2:0], 1'b0};
    return s[3] ? $signed(m) : -$signed(m);
  endfunction

  // rotor may rest with the hall high, so the first cycle after reset only primes
  assign hall_edge = (hall_in ^ hall_q) & hall_primed;
  assign pwm_rise = pwm_in & ~pwm_q;
  assign duty_low = output_duty < tlap_pkg::DUTY_LOW_LIM;

  // input history and hall half-period measurement
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hall_q <= 1'b0;
      hall_primed <= 1'b0;
      pwm_q <= 1'b0;
      per_cnt <= '0;
      period <= '0;
    end else begin
      hall_q <= hall_in;
      hall_primed <= 1'b1;
      pwm_q <= pwm_in;
      if (hall_edge) begin
        period <= per_cnt;
        per_cnt <= '0;
      end else if (per_cnt != '1) begin
        per_cnt <= per_cnt + 1'b1; // saturates on a stopped rotor
      end
    end
  end

  // lead angle between the two duty endpoints
  always_comb begin
    ang_top = to_steps(cfg.advance_at_top_duty, cfg.advance_step_fine);
    ang_bot = to_steps(cfg.advance_at_bottom_duty, cfg.advance_step_fine);
    duty_off = $signed({2'b00, output_duty}) - $signed({2'b00, cfg.bottom_duty});
    duty_span = $signed({2'b00, cfg.top_duty}) - $signed({2'b00, cfg.bottom_duty});
    ang_num = 18'(ang_top - ang_bot) * 18'(duty_off);
    // full drive arrives as duty 255 and simply extrapolates
    if (duty_span > 0) begin
      ang_full = 18'(ang_bot) + ang_num / 18'(duty_span);
    end else begin
      ang_full = 18'(ang_bot);
    end
    // clamp keeps the delay below one half-period
    if (ang_full > ANG_LIM_S) begin
      ang_c = 10'(ANG_LIM_S);
    end else if (ang_full < -ANG_LIM_S) begin
      ang_c = -10'(ANG_LIM_S);
    end else begin
      ang_c = 10'(ang_full);
    end
    ang_mag05 = (ang_c < 0) ? 11'(-ang_c) * 11'(tlap_pkg::STEP_05)
                            : 11'(ang_c) * 11'(tlap_pkg::STEP_05);
  end

  // angle to cycles, scaled by the last half-period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lead_prod <= '0;
      lead_cyc <= '0;
      lead_adv <= 1'b0;
    end else begin
      lead_prod <= (PER_W+11)'(period) * (PER_W+11)'(ang_mag05);
      lead_cyc <= PER_W'(lead_prod / (PER_W+11)'(tlap_pkg::HALF_TURN_05));
      lead_adv <= ang_c > 0;
    end
  end

  // commutation phase shifted from the hall edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= 1'b0;
      com_armed <= 1'b0;
      com_cnt <= '0;
      com_tgt <= '0;
      flip_to <= 1'b0;
    end else if (hall_edge) begin
      com_cnt <= '0;
      com_armed <= 1'b1;
      if (lead_adv) begin
        // ahead: flip early, predicting the next edge from this period
        phase <= hall_in;
        flip_to <= ~hall_in;
        com_tgt <= period - lead_cyc;
      end else begin
        flip_to <= hall_in;
        com_tgt <= lead_cyc;
      end
    end else if (com_armed && com_cnt >= com_tgt) begin
      phase <= flip_to;
      com_armed <= 1'b0;
    end else if (com_armed) begin
      com_cnt <= com_cnt + 1'b1;
    end
  end

  // stall protection decisions
  always_comb begin
    lock_len = (lock_cnt >= tlap_pkg::LOCK_LONG_FROM) ? LOCK_LONG_CYC : LOCK_SHORT_CYC;
    win_len = cfg.retry_window_long ? RETRY_LONG_CYC : RETRY_SHORT_CYC;
    stall_trip = state == tlap_pkg::ST_RUN && !hall_edge && !duty_low && timer >= STALL_CYC;
    lock_done = state == tlap_pkg::ST_LOCKED && timer >= lock_len - 32'h1;
    retry_fail = state == tlap_pkg::ST_RETRY && !duty_low && !hall_edge &&
                 timer >= win_len - 32'h1;
    go_locked = stall_trip | retry_fail;
    drive_ok = (state == tlap_pkg::ST_RUN || state == tlap_pkg::ST_RETRY) && !duty_low;
  end

  // stall state machine and period timer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= tlap_pkg::ST_RUN;
      timer <= '0;
    end else begin
      case (state)
        tlap_pkg::ST_RUN: begin
          if (hall_edge || duty_low) begin
            timer <= '0; // a parked fan is not a stalled one
          end else if (stall_trip) begin
            state <= tlap_pkg::ST_LOCKED;
            timer <= '0;
          end else begin
            timer <= timer + 32'h1;
          end
        end
        tlap_pkg::ST_LOCKED: begin
          // low duty is ignored here on purpose
          if (lock_done) begin
            state <= tlap_pkg::ST_RETRY;
            timer <= '0;
          end else begin
            timer <= timer + 32'h1;
          end
        end
        tlap_pkg::ST_RETRY: begin
          if (duty_low) begin
            state <= tlap_pkg::ST_REARM;
            timer <= '0;
          end else if (hall_edge) begin
            state <= tlap_pkg::ST_RUN;
            timer <= '0;
          end else if (retry_fail) begin
            state <= tlap_pkg::ST_LOCKED;
            timer <= '0;
          end else begin
            timer <= timer + 32'h1;
          end
        end
        tlap_pkg::ST_REARM: begin
          if (pwm_rise) begin
            state <= tlap_pkg::ST_RUN;
          end
          timer <= '0;
        end
        default: begin
          state <= tlap_pkg::ST_RUN;
          timer <= '0;
        end
      endcase
    end
  end

  // lockout repetition count, saturating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_cnt <= '0;
    end else if (state == tlap_pkg::ST_RETRY && duty_low) begin
      lock_cnt <= '0;
    end else if (go_locked && lock_cnt < tlap_pkg::LOCK_LONG_FROM) begin
      lock_cnt <= lock_cnt + 3'h1;
    end
  end

  // stall indicator; entering lockout wins over the clearing count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stall_flag <= 1'b0;
      hall_chg <= '0;
    end else if (go_locked) begin
      stall_flag <= 1'b1;
      hall_chg <= '0;
    end else if (hall_edge && hall_chg < tlap_pkg::HALL_CHG_CLEAR) begin
      hall_chg <= hall_chg + 3'h1;
    end else if (hall_chg >= tlap_pkg::HALL_CHG_CLEAR) begin
      stall_flag <= 1'b0;
    end
  end

  // divided and doubled speed pulses, both start low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_div <= 1'b0;
      half_q <= 1'b0;
      dbl_q <= 1'b0;
      dbl_cnt <= '0;
      dbl_done <= 1'b1;
    end else if (hall_edge) begin
      half_div <= ~half_div;
      half_q <= half_q ^ half_div;
      dbl_q <= ~dbl_q;
      dbl_cnt <= '0;
      dbl_done <= 1'b0;
    end else if (!dbl_done && dbl_cnt >= (period >> 1)) begin
      // mid-edge uses the last period, so duty drifts on speed changes
      dbl_q <= ~dbl_q;
      dbl_done <= 1'b1;
    end else if (!dbl_done) begin
      dbl_cnt <= dbl_cnt + 1'b1;
    end
  end

  // speed pin selection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      speed_pulse_out <= 1'b0;
    end else begin
      case (cfg.tach_output_select)
        tlap_pkg::TACH_BASIC: speed_pulse_out <= hall_q;
        tlap_pkg::TACH_DOUBLE: speed_pulse_out <= dbl_q;
        tlap_pkg::TACH_HALF: speed_pulse_out <= half_q;
        default: speed_pulse_out <= stall_flag ^ cfg.stall_polarity_invert;
      endcase
    end
  end

  // bridge drive, fault priority highest first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bridge_out_a_o <= 1'b0;
      bridge_out_a_oe <= 1'b0;
      bridge_out_b_o <= 1'b0;
      bridge_out_b_oe <= 1'b0;
    end else if (thermal_shutdown || overcurrent_trip || !drive_ok) begin
      // evaluated every cycle, so drive returns when thermal clears
      bridge_out_a_oe <= 1'b0;
      bridge_out_b_oe <= 1'b0;
      bridge_out_a_o <= 1'b0;
      bridge_out_b_o <= 1'b0;
    end else if (low_supply_lockout) begin
      bridge_out_a_o <= 1'b0;
      bridge_out_b_o <= 1'b0;
      bridge_out_a_oe <= !drive_input_a && drive_input_b;
      bridge_out_b_oe <= drive_input_a && !drive_input_b;
    end else if (current_limiter) begin
      // only the low side conducts; the other leg freewheels on its diode
      bridge_out_a_o <= 1'b0;
      bridge_out_b_o <= 1'b0;
      bridge_out_a_oe <= !phase;
      bridge_out_b_oe <= phase;
    end else begin
      bridge_out_a_o <= phase & pwm_carrier;
      bridge_out_b_o <= !phase & pwm_carrier;
      bridge_out_a_oe <= 1'b1;
      bridge_out_b_oe <= 1'b1;
    end
  end

  // apb decode; one wait state, write lands at the completing edge
  assign apb_acc = psel & penable & pready;
  assign apb_wr = apb_acc & pwrite & addr_ok;
  always_comb begin
    addr_ok = 1'b1;
    next_rdata = '0;
    case (paddr)
      tlap_pkg::OFS_CTRL: next_rdata = {19'h0, cfg[28:16]};
      tlap_pkg::OFS_DUTY_EP: next_rdata = {16'h0, cfg[15:0]};
      tlap_pkg::OFS_STATUS: next_rdata = {6'h0, ang_c, 7'h0, hall_q, phase,
                                           1'b0, state, lock_cnt, stall_flag};
      tlap_pkg::OFS_PERIOD: next_rdata = 32'(period);
      default: addr_ok = 1'b0;
    endcase
  end

  // apb answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~addr_ok;
      prdata <= (psel & penable & ~pready & ~pwrite) ? next_rdata : '0;
    end
  end

  // configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= '{retry_window_long: 1'b0, advance_step_fine: 1'b0,
               advance_at_bottom_duty: tlap_pkg::ADV_RST,
               advance_at_top_duty: tlap_pkg::ADV_RST,
               stall_polarity_invert: 1'b0,
               tach_output_select: tlap_pkg::TACH_SEL_RST,
               top_duty: tlap_pkg::TOP_DUTY_RST, bottom_duty: tlap_pkg::BOT_DUTY_RST};
    end else if (apb_wr && paddr == tlap_pkg::OFS_CTRL) begin
      cfg[28:16] <= pwdata[12:0];
    end else if (apb_wr && paddr == tlap_pkg::OFS_DUTY_EP) begin
      cfg[15:0] <= pwdata[15:0];
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_fault_off: assert property ((thermal_shutdown || overcurrent_trip) |=>
    !bridge_out_a_oe && !bridge_out_b_oe) else $error("bridge driven during fault");
  chk_supply_table: assert property (
    (low_supply_lockout && !thermal_shutdown && !overcurrent_trip && drive_ok &&
     !drive_input_a && drive_input_b) |=>
    bridge_out_a_oe && !bridge_out_a_o && !bridge_out_b_oe) else $error("low supply table broken");
  chk_limit_no_pwm: assert property ((current_limiter && !thermal_shutdown &&
    !overcurrent_trip) |=> !(bridge_out_a_oe && bridge_out_a_o) &&
    !(bridge_out_b_oe && bridge_out_b_o)) else $error("high side on in limiter");
  chk_stall_entry: assert property ((state == tlap_pkg::ST_RUN && timer == STALL_CYC &&
    !hall_edge && !duty_low) |=> state == tlap_pkg::ST_LOCKED ##1
    !bridge_out_a_oe && !bridge_out_b_oe) else $error("stall not entered");
  chk_lock_short: assert property ((state == tlap_pkg::ST_LOCKED && lock_cnt < 3'h5 &&
    timer == LOCK_SHORT_CYC - 32'h1) |=> state == tlap_pkg::ST_RETRY)
    else $error("short lockout length wrong");
  chk_lock_hold: assert property ((state == tlap_pkg::ST_LOCKED && timer < lock_len - 32'h1)
    |=> state == tlap_pkg::ST_LOCKED && timer == $past(timer) + 32'h1)
    else $error("lockout left early");
  chk_rearm_reset: assert property ((state == tlap_pkg::ST_RETRY && duty_low) |=>
    state == tlap_pkg::ST_REARM && lock_cnt == 3'h0) else $error("rearm did not reset");
  chk_count_sat: assert property ((go_locked && lock_cnt == 3'h5) |=>
    lock_cnt == 3'h5 ##1 lock_cnt <= 3'h5) else $error("repetition count overflow");
  chk_stall_pin: assert property ((cfg.tach_output_select == tlap_pkg::TACH_STALL) |=>
    speed_pulse_out == ($past(stall_flag) ^ $past(cfg.stall_polarity_invert)))
    else $error("stall indicator level wrong");

  cov_retry: cover property (state == tlap_pkg::ST_LOCKED ##1 state == tlap_pkg::ST_RETRY);
  cov_recover: cover property (state == tlap_pkg::ST_RETRY ##1 state == tlap_pkg::ST_RUN);
  cov_rearm: cover property (state == tlap_pkg::ST_REARM ##1 state == tlap_pkg::ST_RUN);
  cov_long: cover property (state == tlap_pkg::ST_LOCKED && lock_cnt == 3'h5);

endmodule

`default_nettype wire

/* verif/tlap_motor.sv */
// behavioural single-phase fan motor with a hall sensor
`timescale 1ns/1ps
`default_nettype none
module tlap_motor #(
  parameter int HALF_CYC = 20
) (
  // clock
  input wire logic pclk,
  // bridge activity and rotor blocking from the bench
  input wire logic drive_on,
  input wire logic rotor_free,
  // hall sensor level
  output logic hall_in
);
  int phase_cnt = 0;
  logic hall_lvl = 1'b0;
  assign hall_in = hall_lvl;
  // rotor turns only while driven and free; no coasting, so a stall is seen at once
  always @(posedge pclk) begin
    if (drive_on && rotor_free) begin
      phase_cnt <= (phase_cnt >= HALF_CYC - 1) ? 0 : phase_cnt + 1;
      if (phase_cnt >= HALF_CYC - 1) begin
        hall_lvl <= ~hall_lvl;
      end
    end
  end
endmodule
`default_nettype wire

/* verif/tlap_core_bench.sv */
// self-checking bench for the fan-driver motor-side logic
`timescale 1ns/1ps
`default_nettype none
module tlap_core_bench;
  localparam int ST = 32'hC8;
  localparam int LS = 32'h190;
  localparam int LL = 32'h320;
  localparam int RS = 32'h64;
  localparam int RL = 32'h96;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, hall_in, pwm_in, pwm_carrier;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] output_duty;
  logic thermal_shutdown, low_supply_lockout, current_limiter, overcurrent_trip;
  logic drive_input_a, drive_input_b, speed_pulse_out, rotor_free, er, pol, win, drive;
  logic bridge_out_a_o, bridge_out_a_oe, bridge_out_b_o, bridge_out_b_oe;
  logic hall_q, spd_q;
  logic [3:0] hs, ls;
  int bad_count, samples_checked, hall_n, spd_n, n, h0, s0, e;
  assign drive = bridge_out_a_oe | bridge_out_b_oe;

  tlap_core #(.STALL_CYC(ST), .LOCK_SHORT_CYC(LS), .LOCK_LONG_CYC(LL),
    .RETRY_SHORT_CYC(RS), .RETRY_LONG_CYC(RL)) tlap_core_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hall_in(hall_in), .pwm_in(pwm_in), .output_duty(output_duty), .pwm_carrier(pwm_carrier),
    .thermal_shutdown(thermal_shutdown), .low_supply_lockout(low_supply_lockout),
    .current_limiter(current_limiter), .overcurrent_trip(overcurrent_trip),
    .drive_input_a(drive_input_a), .drive_input_b(drive_input_b),
    .bridge_out_a_o(bridge_out_a_o), .bridge_out_a_oe(bridge_out_a_oe),
    .bridge_out_b_o(bridge_out_b_o), .bridge_out_b_oe(bridge_out_b_oe),
    .speed_pulse_out(speed_pulse_out));
  tlap_motor tlap_motor_i (.pclk(pclk), .drive_on(drive), .rotor_free(rotor_free),
    .hall_in(hall_in));

  // clock and random output carrier
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk) pwm_carrier <= 1'($urandom);
  // running counts of hall changes and speed pin changes
  always @(posedge pclk) begin
    hall_q <= hall_in;
    spd_q <= speed_pulse_out;
    if (hall_q !== hall_in) hall_n <= hall_n + 1;
    if (spd_q !== speed_pulse_out) spd_n <= spd_n + 1;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // one apb transfer, request held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // cycles until drive reaches v; dip lowers the duty briefly part way
  task automatic wait_drive(input logic v, input logic dip);
    n = 0;
    while (drive !== v && n < 2000) begin
      @(posedge pclk);
      n++;
      if (dip && n == 100) output_duty <= 8'h00;
      if (dip && n == 150) output_duty <= 8'h80;
    end
  endtask
  function automatic int ang(input logic [3:0] s, input logic fine);
    ang = (s[2:0] * (fine ? 1 : 2)) * (s[3] ? 1 : -1);
  endfunction
  function automatic logic near(input int seen, input int exp, input int tol);
    near = (seen >= exp - tol) && (seen <= exp + tol);
  endfunction

  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    final_report();
  end

  initial begin
    {presetn, psel, penable, pwrite, pwm_in, thermal_shutdown, low_supply_lockout} = 7'h0;
    {current_limiter, overcurrent_trip, drive_input_a, drive_input_b} = 4'h0;
    {paddr, pwdata, output_duty, rotor_free, hall_n, spd_n} = '0;
    {bad_count, samples_checked} = '0;
    void'($urandom(40));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    check(32'(speed_pulse_out), 32'h0);
    apb(1'b0, tlap_pkg::OFS_CTRL, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, tlap_pkg::OFS_DUTY_EP, 32'h0);
    check(rd, 32'h0000FE00);
    apb(1'b0, 12'h010, 32'h0);
    check({er, rd[30:0]}, 32'h80000000);
    output_duty <= 8'h80;
    rotor_free <= 1'b1;
    // speed pin frequency for each pulse selection
    for (int sel = 0; sel < 3; sel++) begin
      apb(1'b1, tlap_pkg::OFS_CTRL, 32'(sel));
      h0 = hall_n;
      s0 = spd_n;
      repeat (800) @(posedge pclk);
      e = (sel == 1) ? 2 * (hall_n - h0) : (sel == 2) ? (hall_n - h0) / 2 : hall_n - h0;
      check(32'(near(spd_n - s0, e, 1)), 32'h1);
    end
    // thermal and overcurrent cut the bridge; thermal release resumes
    for (int f = 0; f < 2; f++) begin
      if (f == 0) thermal_shutdown <= 1'b1;
      else overcurrent_trip <= 1'b1;
      repeat (3) @(posedge pclk);
      check(32'(drive), 32'h0);
      thermal_shutdown <= 1'b0;
      overcurrent_trip <= 1'b0;
      repeat (3) @(posedge pclk);
      if (f == 0) check(32'(drive), 32'h1);
    end
    // low supply pattern for input pairs 01 and 10
    for (int p = 1; p < 3; p++) begin
      {drive_input_a, drive_input_b} <= 2'(p);
      low_supply_lockout <= 1'b1;
      repeat (3) @(posedge pclk);
      e = (p == 1) ? 32'h8 : 32'h2;
      check({bridge_out_a_oe, bridge_out_a_o, bridge_out_b_oe, bridge_out_b_o}, e);
    end
    low_supply_lockout <= 1'b0;
    // current limiter never drives an output high whatever the carrier does
    current_limiter <= 1'b1;
    repeat (3) @(posedge pclk);
    repeat (8) begin
      @(posedge pclk);
      check(32'((bridge_out_a_oe & bridge_out_a_o) | (bridge_out_b_oe & bridge_out_b_o)), 32'h0);
    end
    current_limiter <= 1'b0;
    // lead angle at both endpoints and extrapolated at full drive
    apb(1'b1, tlap_pkg::OFS_DUTY_EP, 32'h00005500);
    for (int fine = 0; fine < 2; fine++) begin
      hs = 4'($urandom);
      ls = 4'($urandom);
      apb(1'b1, tlap_pkg::OFS_CTRL, {20'h0, 1'(fine), ls, hs, 3'h0});
      for (int d = 0; d < 3; d++) begin
        output_duty <= (d == 0) ? 8'h00 : (d == 1) ? 8'h55 : 8'hFF;
        repeat (4) @(posedge pclk);
        apb(1'b0, tlap_pkg::OFS_STATUS, 32'h0);
        e = (d == 0) ? ang(ls, fine) : (d == 1) ? ang(hs, fine)
          : 3 * ang(hs, fine) - 2 * ang(ls, fine);
        check({22'h0, rd[25:16]}, {22'h0, 10'(e)});
      end
    end
    output_duty <= 8'h80;
    // stall, timed lockout periods and retry windows
    pol = 1'($urandom);
    win = 1'($urandom);
    apb(1'b1, tlap_pkg::OFS_CTRL, {19'h0, win, 9'h0, pol, tlap_pkg::TACH_STALL});
    repeat (100) @(posedge pclk);
    check(32'(speed_pulse_out), 32'(pol));
    rotor_free <= 1'b0;
    wait_drive(1'b0, 1'b0);
    check(32'(near(n, ST - 8, 12)), 32'h1);
    check(32'(speed_pulse_out), 32'(!pol));
    for (int k = 1; k <= 7; k++) begin
      if (k == 7) begin
        apb(1'b0, tlap_pkg::OFS_STATUS, 32'h0);
        check({26'h0, rd[5:1]}, 32'h0D);
      end
      wait_drive(1'b1, k == 1);
      if (k < 7) check(32'(near(n + (k == 7 ? 0 : 0), (k <= 4) ? LS : LL, 2)), 32'h1);
      if (k < 7) wait_drive(1'b0, 1'b0);
      if (k < 7) check(32'(near(n, win ? RL : RS, 2)), 32'h1);
    end
    // low duty in the retry window rearms; pwm rise restarts
    output_duty <= 8'h00;
    repeat (4) @(posedge pclk);
    apb(1'b0, tlap_pkg::OFS_STATUS, 32'h0);
    check({26'h0, rd[5:1], drive}, 32'h30);
    output_duty <= 8'h80;
    rotor_free <= 1'b1;
    repeat (10) @(posedge pclk);
    check({30'h0, drive, speed_pulse_out}, {31'h0, ~pol});
    pwm_in <= 1'b1;
    h0 = hall_n;
    n = 0;
    while (speed_pulse_out !== pol && n < 500) begin
      @(posedge pclk);
      n++;
    end
    check(32'(hall_n - h0), 32'h4);
    apb(1'b0, tlap_pkg::OFS_STATUS, 32'h0);
    check({30'h0, rd[5:4]}, 32'h0);
    pwm_in <= 1'b0;
    // mid-run reset with the hall high: half mode must not see a false edge
    while (hall_in !== 1'b1 || hall_q !== 1'b0) @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    h0 = hall_n;
    apb(1'b1, tlap_pkg::OFS_CTRL, 32'h2);
    while (hall_n == h0) @(posedge pclk);
    repeat (5) @(posedge pclk);
    check(32'(speed_pulse_out), 32'h0);
    final_report();
  end
endmodule
`default_nettype wire
